// >>> drive_link_command_handler.sv
// instruction, frequency, monitor and reset handling of the drive link slave
`timescale 1ns/100ps
`default_nettype none
module drive_link_command_handler (
  input wire logic mclk,
  input wire logic rst_n,
  // master side, asynchronous to mclk
  input wire logic instruction_execute_request,
  input wire logic [7:0] instruction_code,
  input wire logic [15:0] instruction_data,
  input wire logic [7:0] link_ext_setting,
  input wire logic [15:0] monitor_code,
  input wire logic frequency_write_command,
  input wire logic frequency_nonvolatile_write_command,
  input wire logic [15:0] frequency_set_data,
  input wire logic error_reset_request,
  // drive side, on mclk
  input wire logic [15:0] output_frequency,
  input wire logic fault_present,
  input wire logic [7:0] fault_history_1,
  input wire logic [7:0] fault_history_2,
  input wire logic [15:0] reset_acceptance_selection,
  input wire logic [7:0] startup_mode_selection,
  // results
  output logic network_mode,
  output logic [15:0] reply_code,
  output logic [15:0] response_data,
  output logic instruction_done,
  output logic [15:0] monitor_value,
  output logic [15:0] acceleration_time_param,
  output logic [15:0] running_frequency,
  output logic frequency_write_done,
  output logic nv_write_strobe,
  output logic [15:0] nv_write_data,
  output logic frequency_nonvolatile_write_done,
  output logic drive_reset_pulse,
  output logic error_reset_pulse
);
  import drive_link_pkg::*;

  localparam int SYNC_W = 68; // width of the bundled master inputs

  typedef enum logic [1:0] {CMD_IDLE, CMD_EXEC, CMD_DONE} cmd_state_t;

  // two-stage synchroniser for every master input; multi-bit words are
  // safe because the master holds them stable around its request bits
  logic [SYNC_W-1:0] sync_a_q, sync_b_q;
  logic [SYNC_W-1:0] sync_in;
  logic exec_s, freq_cmd_s, nv_cmd_s, err_req_s; // synchronised levels
  logic [7:0] code_s, ext_s;
  logic [15:0] data_s, mon_code_s, freq_data_s;

  assign sync_in = {instruction_execute_request, instruction_code, instruction_data,
                    link_ext_setting, monitor_code, frequency_write_command,
                    frequency_nonvolatile_write_command, frequency_set_data, error_reset_request};
  assign {exec_s, code_s, data_s, ext_s, mon_code_s, freq_cmd_s, nv_cmd_s, freq_data_s, err_req_s} = sync_b_q;

  // synchroniser stages; only the second stage is read by logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= sync_in;
      sync_b_q <= sync_a_q;
    end
  end

  // instruction state
  cmd_state_t st_q, st_d;
  logic exec_prev_q, exec_prev_d; // edge detect on the execute request
  logic [15:0] reply_q, reply_d;
  logic [15:0] resp_q, resp_d;
  logic done_q, done_d;
  logic net_q, net_d; // network operation mode
  logic boot_q, boot_d; // first cycle after reset release
  logic [15:0] accel_q, accel_d;
  logic drst_q, drst_d; // drive reset pulse
  logic low_page; // extended setting addresses parameters below 100

  assign low_page = (ext_s == EXT_PAGE_LOW);

  // instruction decode: the reply is computed in CMD_EXEC and done follows
  // one cycle later, so the master never sees done with a stale reply
  always_comb begin
    st_d = st_q;
    exec_prev_d = exec_s;
    reply_d = reply_q;
    resp_d = resp_q;
    done_d = done_q;
    net_d = net_q;
    boot_d = 1'b0;
    accel_d = accel_q;
    drst_d = 1'b0;
    if (boot_q) begin
      net_d = (startup_mode_selection != STARTUP_EXTERNAL); // startup mode taken after release
    end
    case (st_q)
      CMD_IDLE: begin
        if (exec_s && !exec_prev_q) begin
          st_d = CMD_EXEC;
        end
      end
      CMD_EXEC: begin
        st_d = CMD_DONE;
        reply_d = REPLY_OK;
        case (code_s)
          CODE_MODE_WRITE: begin
            if (data_s == DATA_NET_MODE) begin
              net_d = 1'b1;
            end else if (data_s == DATA_EXT_MODE) begin
              net_d = 1'b0;
            end else begin
              reply_d = REPLY_BAD_DATA;
            end
          end
          CODE_ACCEL_READ: begin
            // pages above the low one address parameters this block lacks
            if (low_page) begin
              resp_d = accel_q;
            end else begin
              reply_d = REPLY_BAD_CODE;
            end
          end
          CODE_ACCEL_WRITE: begin
            if (low_page) begin
              accel_d = data_s;
            end else begin
              reply_d = REPLY_BAD_CODE;
            end
          end
          CODE_FAULT_READ: begin
            resp_d = {fault_history_2, fault_history_1};
          end
          CODE_DRIVE_RESET: begin
            if (data_s != DATA_RESET_KEY) begin
              reply_d = REPLY_BAD_DATA;
            end else if (net_q || startup_mode_selection != STARTUP_EXTERNAL) begin
              drst_d = 1'b1;
            end else begin
              reply_d = REPLY_BAD_MODE;
            end
          end
          default: begin
            reply_d = REPLY_BAD_CODE;
          end
        endcase
      end
      CMD_DONE: begin
        done_d = 1'b1;
        if (!exec_s) begin
          done_d = 1'b0; // handshake closes when the master drops the request
          st_d = CMD_IDLE;
        end
      end
      default: begin
        st_d = CMD_IDLE;
      end
    endcase
  end

  // instruction registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= CMD_IDLE;
      exec_prev_q <= 1'b0;
      reply_q <= REPLY_OK;
      resp_q <= 16'h0000;
      done_q <= 1'b0;
      net_q <= 1'b0;
      boot_q <= 1'b1;
      accel_q <= ACCEL_TIME_RESET;
      drst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      exec_prev_q <= exec_prev_d;
      reply_q <= reply_d;
      resp_q <= resp_d;
      done_q <= done_d;
      net_q <= net_d;
      boot_q <= boot_d;
      accel_q <= accel_d;
      drst_q <= drst_d;
    end
  end

  // frequency, monitor and error reset state
  logic freq_prev_q, freq_prev_d;
  logic [15:0] run_freq_q, run_freq_d;
  logic freq_done_q, freq_done_d;
  logic [15:0] mon_q, mon_d;
  logic err_prev_q, err_prev_d;
  logic erst_q, erst_d;
  logic nv_strobe, nv_done;
  logic [15:0] nv_data;

  // the set data is taken as is, in 0.01 Hz steps; monitor passes the
  // drive's output frequency through in the same units
  always_comb begin
    freq_prev_d = freq_cmd_s;
    run_freq_d = run_freq_q;
    freq_done_d = freq_done_q;
    err_prev_d = err_req_s;
    erst_d = 1'b0;
    mon_d = 16'h0000;
    if (mon_code_s == MON_OUTPUT_FREQ) begin
      mon_d = output_frequency;
    end
    if (freq_cmd_s && !freq_prev_q) begin
      run_freq_d = freq_data_s;
    end else if (nv_strobe) begin
      run_freq_d = nv_data; // a stored frequency also becomes the running one
    end
    freq_done_d = freq_cmd_s && freq_prev_q; // done one cycle after the load
    if (err_req_s && !err_prev_q &&
        (fault_present || reset_any_mode(reset_acceptance_selection))) begin
      erst_d = 1'b1;
    end
  end

  // frequency, monitor and error reset registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      freq_prev_q <= 1'b0;
      run_freq_q <= RUN_FREQ_RESET;
      freq_done_q <= 1'b0;
      mon_q <= 16'h0000;
      err_prev_q <= 1'b0;
      erst_q <= 1'b0;
    end else begin
      freq_prev_q <= freq_prev_d;
      run_freq_q <= run_freq_d;
      freq_done_q <= freq_done_d;
      mon_q <= mon_d;
      err_prev_q <= err_prev_d;
      erst_q <= erst_d;
    end
  end

  freq_nv_writer u_nv (
    .mclk(mclk),
    .rst_n(rst_n),
    .nv_cmd(nv_cmd_s),
    .set_data(freq_data_s),
    .nv_write_strobe(nv_strobe),
    .nv_write_data(nv_data),
    .nv_done(nv_done)
  );

  assign network_mode = net_q;
  assign reply_code = reply_q;
  assign response_data = resp_q;
  assign instruction_done = done_q;
  assign monitor_value = mon_q;
  assign acceleration_time_param = accel_q;
  assign running_frequency = run_freq_q;
  assign frequency_write_done = freq_done_q;
  assign nv_write_strobe = nv_strobe;
  assign nv_write_data = nv_data;
  assign frequency_nonvolatile_write_done = nv_done;
  assign drive_reset_pulse = drst_q;
  assign error_reset_pulse = erst_q;

  a_net_mode_switch: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == CMD_EXEC && code_s == CODE_MODE_WRITE && data_s == DATA_NET_MODE) |=> net_q ##1 done_q)
    else $error("network mode not selected by mode write");
  a_monitor_freq: assert property (@(posedge mclk) disable iff (!rst_n)
    (mon_code_s == MON_OUTPUT_FREQ) |=> (mon_q == $past(output_frequency)))
    else $error("monitor does not show output frequency");
  a_accel_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == CMD_EXEC && code_s == CODE_ACCEL_READ && low_page) |=> (resp_q == accel_q && reply_q == REPLY_OK))
    else $error("acceleration read returned wrong data");
  a_accel_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == CMD_EXEC && code_s == CODE_ACCEL_WRITE && low_page) |=> (accel_q == $past(data_s)))
    else $error("acceleration write not stored");
  a_high_page_reject: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == CMD_EXEC && code_s == CODE_ACCEL_WRITE && !low_page) |=> (reply_q == REPLY_BAD_CODE && $stable(accel_q)))
    else $error("write accepted on wrong extended page");
  a_freq_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (freq_cmd_s && !freq_prev_q) |=> (run_freq_q == $past(freq_data_s)) ##1 (freq_done_q || !freq_cmd_s))
    else $error("running frequency not loaded or done missing");
  a_fault_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == CMD_EXEC && code_s == CODE_FAULT_READ) |=> (resp_q == {$past(fault_history_2), $past(fault_history_1)}))
    else $error("fault history read wrong");
  a_err_reset_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    erst_q |-> $past(fault_present || reset_any_mode(reset_acceptance_selection)))
    else $error("error reset taken without fault or permission");
  a_drive_reset_key: assert property (@(posedge mclk) disable iff (!rst_n)
    drst_q |-> $past(code_s == CODE_DRIVE_RESET && data_s == DATA_RESET_KEY
                     && (net_q || startup_mode_selection != STARTUP_EXTERNAL)))
    else $error("drive reset without key or permission");
  a_reply_before_done: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(done_q) |-> $stable(reply_q) && $past(st_q == CMD_DONE))
    else $error("reply changed as completion rose");

  c_mode_write: cover property (@(posedge mclk) disable iff (!rst_n) $rose(net_q));
  c_accel_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    st_q == CMD_EXEC && code_s == CODE_ACCEL_WRITE ##[2:20] st_q == CMD_EXEC && code_s == CODE_ACCEL_READ);
  c_freq_done: cover property (@(posedge mclk) disable iff (!rst_n) $rose(freq_done_q));
  c_drive_reset: cover property (@(posedge mclk) disable iff (!rst_n) drst_q);
endmodule
`default_nettype wire

// >>> drive_link_pkg.sv
// constants, codes and helper functions shared by the drive link command handler
`default_nettype none
package drive_link_pkg;
  // instruction codes
  localparam logic [7:0] CODE_ACCEL_READ = 8'h07;
  localparam logic [7:0] CODE_ACCEL_WRITE = 8'h87;
  localparam logic [7:0] CODE_FAULT_READ = 8'h74;
  localparam logic [7:0] CODE_MODE_WRITE = 8'hFB;
  localparam logic [7:0] CODE_DRIVE_RESET = 8'hFD;
  // set data values with a fixed meaning
  localparam logic [15:0] DATA_NET_MODE = 16'h0000;
  localparam logic [15:0] DATA_EXT_MODE = 16'h0010;
  localparam logic [15:0] DATA_RESET_KEY = 16'h9696;
  // monitor selection
  localparam logic [15:0] MON_OUTPUT_FREQ = 16'h0001;
  // extended setting page that holds the low parameters
  localparam logic [7:0] EXT_PAGE_LOW = 8'h00;
  // reply codes
  localparam logic [15:0] REPLY_OK = 16'h0000;
  localparam logic [15:0] REPLY_BAD_CODE = 16'h0001;
  localparam logic [15:0] REPLY_BAD_DATA = 16'h0002;
  localparam logic [15:0] REPLY_BAD_MODE = 16'h0003;
  // reset values
  localparam logic [15:0] ACCEL_TIME_RESET = 16'h0032;
  localparam logic [15:0] RUN_FREQ_RESET = 16'h0000;
  localparam logic [7:0] STARTUP_EXTERNAL = 8'h00;

  // true for selection values that allow error reset in any mode
  function automatic logic reset_any_mode(input logic [15:0] sel);
    case (sel)
      16'h0000, 16'h0064, 16'h03E8, 16'h044C,
      16'h2710, 16'h2774, 16'h2AF8, 16'h2B5C: reset_any_mode = 1'b1;
      default: reset_any_mode = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> freq_nv_writer.sv
// one-shot nonvolatile store of the running frequency set data
`timescale 1ns/100ps
`default_nettype none
module freq_nv_writer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic nv_cmd, // synchronised command level
  input wire logic [15:0] set_data, // synchronised set data
  output logic nv_write_strobe,
  output logic [15:0] nv_write_data,
  output logic nv_done
);
  import drive_link_pkg::*;

  logic cmd_prev_q, cmd_prev_d; // last command level, for edge detect
  logic strobe_q, strobe_d;
  logic [15:0] data_q, data_d; // value latched at the rising edge
  logic done_q, done_d;

  // latch only at the rising edge; later data changes are ignored on purpose
  always_comb begin
    cmd_prev_d = nv_cmd;
    strobe_d = 1'b0;
    data_d = data_q;
    done_d = done_q;
    if (nv_cmd && !cmd_prev_q) begin
      strobe_d = 1'b1;
      data_d = set_data;
    end
    if (!nv_cmd) begin
      done_d = 1'b0; // done drops with the command
    end else if (strobe_q) begin
      done_d = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_prev_q <= 1'b0;
      strobe_q <= 1'b0;
      data_q <= RUN_FREQ_RESET;
      done_q <= 1'b0;
    end else begin
      cmd_prev_q <= cmd_prev_d;
      strobe_q <= strobe_d;
      data_q <= data_d;
      done_q <= done_d;
    end
  end

  assign nv_write_strobe = strobe_q;
  assign nv_write_data = data_q;
  assign nv_done = done_q;

  a_nv_single_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_q |=> !strobe_q until !nv_cmd)
    else $error("nonvolatile write repeated within one assertion");
  a_nv_data_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    (nv_cmd && cmd_prev_q && !strobe_d) |=> $stable(data_q))
    else $error("nonvolatile data changed while command held");
  c_nv_write: cover property (@(posedge mclk) disable iff (!rst_n) strobe_q ##1 done_q);
endmodule
`default_nettype wire

// >>> master_station_model.sv
// behavioural master station: instructions and frequency writes over the cyclic bits
`timescale 1ns/100ps
`default_nettype none
module master_station_model (
  input wire logic mclk,
  input wire logic instruction_done,
  input wire logic [15:0] reply_code,
  input wire logic [15:0] response_data,
  input wire logic frequency_write_done,
  input wire logic frequency_nonvolatile_write_done,
  output logic instruction_execute_request,
  output logic [7:0] instruction_code,
  output logic [15:0] instruction_data,
  output logic [7:0] link_ext_setting,
  output logic frequency_write_command,
  output logic frequency_nonvolatile_write_command,
  output logic [15:0] frequency_set_data
);
  import drive_link_pkg::*;
  int n; // cycles spent in the current wait
  int fails = 0; // waits that ran out, or non-zero replies seen before new set data
  // idle master: nothing requested
  initial begin
    instruction_execute_request = 1'b0;
    instruction_code = 8'h00;
    instruction_data = 16'h0000;
    link_ext_setting = 8'h00;
    frequency_write_command = 1'b0;
    frequency_nonvolatile_write_command = 1'b0;
    frequency_set_data = 16'h0000;
  end
  // status picked by index: 0 instruction, 1 frequency, 2 nonvolatile
  function automatic logic lvl(input int s);
    case (s)
      0: lvl = instruction_done;
      1: lvl = frequency_write_done;
      default: lvl = frequency_nonvolatile_write_done;
    endcase
  endfunction
  // bounded, so a silent design shows as a mismatch rather than a hang
  task automatic await(input int s, input logic v);
    n = 0;
    while (lvl(s) !== v && n < 60) begin
      @(posedge mclk);
      n++;
    end
    // a wait that runs out is reported to the bench through this count
    if (lvl(s) !== v) begin
      fails++;
    end
  endtask
  // code and data settle one edge before the request, held through done
  task automatic issue(input logic [7:0] c, input logic [15:0] d, input logic [7:0] e,
                       output logic [15:0] rp, output logic [15:0] rs);
    @(posedge mclk);
    link_ext_setting <= e;
    instruction_code <= c;
    instruction_data <= d;
    @(posedge mclk);
    instruction_execute_request <= 1'b1;
    await(0, 1'b1);
    rp = reply_code;
    rs = response_data;
    instruction_execute_request <= 1'b0;
    await(0, 1'b0);
  endtask
  // plain frequency write; new data only after completion
  task automatic set_freq(input logic [15:0] v);
    @(posedge mclk);
    frequency_set_data <= v;
    @(posedge mclk);
    frequency_write_command <= 1'b1;
    await(1, 1'b1);
    // a reply other than REPLY_OK at frequency done is counted in fails; the next set data still goes out
    if (reply_code !== REPLY_OK) begin
      fails++;
    end
    frequency_write_command <= 1'b0;
    await(1, 1'b0);
  endtask
  // nonvolatile write; data is disturbed while the command is held
  task automatic nv_write(input logic [15:0] v, input logic [15:0] alt);
    @(posedge mclk);
    frequency_set_data <= v;
    @(posedge mclk);
    frequency_nonvolatile_write_command <= 1'b1;
    await(2, 1'b1);
    frequency_set_data <= alt;
    repeat (4) @(posedge mclk);
    frequency_nonvolatile_write_command <= 1'b0;
    await(2, 1'b0);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the drive link command handler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import drive_link_pkg::*;
  logic mclk = 1'b0; // 250 MHz
  logic rst_n = 1'b0; // synchronous, active low
  logic instruction_execute_request, frequency_write_command, frequency_nonvolatile_write_command;
  logic [7:0] instruction_code, link_ext_setting;
  logic [15:0] instruction_data, frequency_set_data;
  logic [15:0] monitor_code = 16'h0000;
  logic error_reset_request = 1'b0;
  logic [15:0] output_frequency = 16'h0000;
  logic fault_present = 1'b0;
  logic [7:0] fault_history_1 = 8'h00;
  logic [7:0] fault_history_2 = 8'h00;
  logic [15:0] reset_acceptance_selection = 16'h0001;
  logic [7:0] startup_mode_selection = 8'h00;
  logic network_mode, instruction_done, frequency_write_done, nv_write_strobe;
  logic frequency_nonvolatile_write_done, drive_reset_pulse, error_reset_pulse;
  logic [15:0] reply_code, response_data, monitor_value, acceleration_time_param;
  logic [15:0] running_frequency, nv_write_data;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0; // timeout counter
  int n_drst = 0; // drive reset pulses seen
  int n_err = 0; // error reset pulses seen
  int n_nv = 0; // nonvolatile strobes seen
  int i, c0;
  logic [31:0] seed = 32'h5D88;
  logic [15:0] v, rp, rs;
  // selection values: the first eight allow reset without a fault
  logic [15:0] sels [11] = '{16'h0000, 16'h0064, 16'h03E8, 16'h044C, 16'h2710, 16'h2774,
                             16'h2AF8, 16'h2B5C, 16'h0001, 16'h0065, 16'h0001};

  drive_link_command_handler uut (.mclk, .rst_n, .instruction_execute_request, .instruction_code,
    .instruction_data, .link_ext_setting, .monitor_code, .frequency_write_command,
    .frequency_nonvolatile_write_command, .frequency_set_data, .error_reset_request, .output_frequency,
    .fault_present, .fault_history_1, .fault_history_2, .reset_acceptance_selection,
    .startup_mode_selection, .network_mode, .reply_code, .response_data, .instruction_done,
    .monitor_value, .acceleration_time_param, .running_frequency, .frequency_write_done,
    .nv_write_strobe, .nv_write_data, .frequency_nonvolatile_write_done, .drive_reset_pulse,
    .error_reset_pulse);
  master_station_model m (.mclk, .instruction_done, .reply_code, .response_data, .frequency_write_done,
    .frequency_nonvolatile_write_done, .instruction_execute_request, .instruction_code,
    .instruction_data, .link_ext_setting, .frequency_write_command,
    .frequency_nonvolatile_write_command, .frequency_set_data);

  // free-running clock
  always #2 mclk = ~mclk;
  // pulse counters, so one-cycle outputs are never missed
  always @(posedge mclk) begin
    if (rst_n === 1'b1) begin
      n_drst += (drive_reset_pulse === 1'b1);
      n_err += (error_reset_pulse === 1'b1);
      n_nv += (nv_write_strobe === 1'b1);
    end
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // xorshift source, fixed seed
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // monitor reads output frequency only for its own code
  function automatic logic [15:0] exp_mon(input logic [15:0] c, input logic [15:0] f);
    return (c == MON_OUTPUT_FREQ) ? f : 16'h0000;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check("accel_reset", acceleration_time_param, ACCEL_TIME_RESET);
    check("mode_reset", {15'h0000, network_mode}, 16'h0000);
    // reset key refused outside network mode with startup strap zero
    c0 = n_drst;
    m.issue(CODE_DRIVE_RESET, DATA_RESET_KEY, 8'h00, rp, rs);
    check("key_refused", rp, REPLY_BAD_MODE);
    check("key_no_pulse", 16'(n_drst - c0), 16'h0000);
    m.issue(CODE_MODE_WRITE, DATA_NET_MODE, 8'h00, rp, rs);
    check("mode_reply", rp, REPLY_OK);
    check("net_mode", {15'h0000, network_mode}, 16'h0001);
    m.issue(CODE_DRIVE_RESET, 16'h1234, 8'h00, rp, rs);
    check("bad_key", rp, REPLY_BAD_DATA);
    m.issue(CODE_DRIVE_RESET, DATA_RESET_KEY, 8'h00, rp, rs);
    check("key_reply", rp, REPLY_OK);
    check("key_pulse", 16'(n_drst - c0), 16'h0001);
    // mode write with unknown data is refused and keeps the mode
    m.issue(CODE_MODE_WRITE, 16'h0005, 8'h00, rp, rs);
    check("mode_bad_data", rp, REPLY_BAD_DATA);
    check("mode_kept", {15'h0000, network_mode}, 16'h0001);
    // acceleration time write then read back, 30 = 3.0 s first
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h001E : (rnd() & 16'h0FFF);
      m.issue(CODE_ACCEL_WRITE, v, 8'h00, rp, rs);
      check("accel_wr_reply", rp, REPLY_OK);
      check("accel_param", acceleration_time_param, v);
      m.issue(CODE_ACCEL_READ, 16'h0000, 8'h00, rp, rs);
      check("accel_read", rs, v);
    end
    // extended page set: accel code no longer addresses it
    m.issue(CODE_ACCEL_WRITE, 16'h0005, 8'h08, rp, rs);
    check("ext_reply", rp, REPLY_BAD_CODE);
    check("ext_untouched", acceleration_time_param, v);
    m.issue(CODE_ACCEL_READ, 16'h0000, 8'h08, rp, rs);
    check("ext_rd_reply", rp, REPLY_BAD_CODE);
    check("ext_rd_data", rs, v);
    m.issue(8'h55, 16'h0000, 8'h00, rp, rs);
    check("bad_code", rp, REPLY_BAD_CODE);
    fault_history_1 <= 8'(rnd() >> 8);
    fault_history_2 <= 8'(rnd() >> 8);
    m.issue(CODE_FAULT_READ, 16'h0000, 8'h00, rp, rs);
    check("fault_hist", rs, {fault_history_2, fault_history_1});
    // monitor: 60 Hz reads as 6000, other codes read zero
    for (i = 0; i < 4; i++) begin
      monitor_code <= (i % 2 == 0) ? MON_OUTPUT_FREQ : (rnd() | 16'h0002);
      output_frequency <= (i == 0) ? 16'h1770 : rnd();
      repeat (6) @(posedge mclk);
      check("monitor", monitor_value, exp_mon(monitor_code, output_frequency));
    end
    // running frequency, 5000 = 50.00 Hz first
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h1388 : rnd();
      m.set_freq(v);
      check("run_freq", running_frequency, v);
    end
    // two nonvolatile writes, each a single strobe despite data changes
    for (i = 0; i < 2; i++) begin
      v = rnd();
      c0 = n_nv;
      m.nv_write(v, ~v);
      check("nv_count", 16'(n_nv - c0), 16'h0001);
      check("nv_data", nv_write_data, v);
      check("nv_run_freq", running_frequency, v);
    end
    // error reset across the eight permitting selection values, two refusing ones, and with a fault
    for (i = 0; i < 11; i++) begin
      fault_present <= (i == 10);
      reset_acceptance_selection <= sels[i];
      c0 = n_err;
      @(posedge mclk);
      error_reset_request <= 1'b1;
      repeat (6) @(posedge mclk);
      error_reset_request <= 1'b0;
      repeat (4) @(posedge mclk);
      check("err_reset", 16'(n_err - c0), (i < 8 || i == 10) ? 16'h0001 : 16'h0000);
    end
    // second reset with the startup strap set comes up in network mode
    rst_n <= 1'b0;
    startup_mode_selection <= 8'h01;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check("strap_mode", {15'h0000, network_mode}, 16'h0001);
    check("accel_reset2", acceleration_time_param, ACCEL_TIME_RESET);
    // back to external mode; the startup strap alone now permits the keyed reset
    m.issue(CODE_MODE_WRITE, DATA_EXT_MODE, 8'h00, rp, rs);
    check("ext_mode", {15'h0000, network_mode}, 16'h0000);
    c0 = n_drst;
    m.issue(CODE_DRIVE_RESET, DATA_RESET_KEY, 8'h00, rp, rs);
    check("strap_key_reply", rp, REPLY_OK);
    check("strap_key_pulse", 16'(n_drst - c0), 16'h0001);
    check("model_fails", 16'(m.fails), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
